// ==== verilog/pfs_pkg.sv ====
// Package with the constants and types of the program flow sequencer.
package pfs_pkg;

  // Widths of the instruction side buses.
  localparam int PFS_PC_W = 24;
  localparam int PFS_CNT_W = 16;
  localparam int PFS_STALL_W = 3;

  // Register offsets on the APB bus, byte addresses.
  localparam logic [7:0] PFS_CTRL_OFF = 8'h00;
  localparam logic [7:0] PFS_STATUS_OFF = 8'h04;
  localparam logic [7:0] PFS_REPCNT_OFF = 8'h08;
  localparam logic [7:0] PFS_LOOPCNT_OFF = 8'h0C;

  // Field positions and reset values.
  localparam int PFS_CTRL_EXT_BIT = 0;
  localparam logic PFS_CTRL_EXT_RST = 1'b0;
  localparam int PFS_ST_PSAVE_BIT = 0;
  localparam int PFS_ST_PSMODE_BIT = 1;
  localparam int PFS_ST_REP_BIT = 2;
  localparam int PFS_ST_LOOP_BIT = 3;
  localparam int PFS_ST_BLOCK_BIT = 4;
  localparam int PFS_ST_BUSY_BIT = 5;

  // Cycle counts of the instruction classes.
  localparam logic [PFS_STALL_W-1:0] PFS_CYC_ONE = 3'h1;
  localparam logic [PFS_STALL_W-1:0] PFS_CYC_SKIP1 = 3'h2;
  localparam logic [PFS_STALL_W-1:0] PFS_CYC_SKIP2 = 3'h3;
  localparam logic [PFS_STALL_W-1:0] PFS_CYC_XFER = 3'h2;
  localparam logic [PFS_STALL_W-1:0] PFS_CYC_XFER_EXT = 3'h4;
  localparam logic [PFS_STALL_W-1:0] PFS_CYC_CPB_EXT = 3'h5;
  localparam logic [PFS_STALL_W-1:0] PFS_CYC_LONG = 3'h4;
  localparam logic [PFS_STALL_W-1:0] PFS_CYC_RET = 3'h3;
  localparam logic [PFS_STALL_W-1:0] PFS_CYC_RET_EXC = 3'h2;
  localparam logic [PFS_STALL_W-1:0] PFS_CYC_RET_EXT_ADD = 3'h3;
  localparam logic [PFS_STALL_W-1:0] PFS_CYC_TWO = 3'h2;

  // Address step from a two-word loop instruction to its first body word.
  localparam logic [PFS_PC_W-1:0] PFS_LOOP_BODY_STEP = 24'h000004;

  // Instruction classes presented by the decoder.
  typedef enum logic [4:0] {
    PFS_OTHER = 5'h00,
    PFS_SKIP = 5'h01,
    PFS_CMP_BRANCH = 5'h02,
    PFS_COND_BRANCH = 5'h03,
    PFS_XFER = 5'h04,
    PFS_LONG_CALL = 5'h05,
    PFS_LONG_JUMP = 5'h06,
    PFS_RETURN = 5'h07,
    PFS_INT_RETURN = 5'h08,
    PFS_RET_LIT = 5'h09,
    PFS_HW_LOOP = 5'h0A,
    PFS_REPEAT = 5'h0B,
    PFS_INTERRUPT_DISABLE_TIMED = 5'h0C,
    PFS_PSAVE = 5'h0D,
    PFS_DPOP = 5'h0E,
    PFS_DPUSH = 5'h0F
  } pfs_class_e;

  // Branch conditions.
  typedef enum logic [4:0] {
    PFS_C_ALWAYS = 5'h00,
    PFS_C_C = 5'h01,
    PFS_C_NC = 5'h02,
    PFS_C_Z = 5'h03,
    PFS_C_NZ = 5'h04,
    PFS_C_N = 5'h05,
    PFS_C_NN = 5'h06,
    PFS_C_OV = 5'h07,
    PFS_C_NOV = 5'h08,
    PFS_C_GT = 5'h09,
    PFS_C_GE = 5'h0A,
    PFS_C_LT = 5'h0B,
    PFS_C_LE = 5'h0C,
    PFS_C_GTU = 5'h0D,
    PFS_C_GEU = 5'h0E,
    PFS_C_LTU = 5'h0F,
    PFS_C_LEU = 5'h10,
    PFS_C_OA = 5'h11,
    PFS_C_OB = 5'h12,
    PFS_C_SA = 5'h13,
    PFS_C_SB = 5'h14
  } pfs_cond_e;

  // Sequencer states.
  typedef enum logic [1:0] {
    PFS_RUN = 2'b00,
    PFS_STALL = 2'b01,
    PFS_SLEEP = 2'b10
  } pfs_state_e;

endpackage

// ==== verilog/pfs_counter.sv ====
// Loadable down counter with an armed flag, shared by repeat, loop and timed block.
`timescale 1ns/1ns
`default_nettype none
module pfs_counter #(
  parameter int W = 16
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Control.
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic step,
  // State.
  output logic [W-1:0] value,
  output logic armed
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic arm;
  } pfs_cnt_s;

  pfs_cnt_s q;
  pfs_cnt_s d;

  // A load wins over a step; a step at zero ends the run, so a load of n gives n + 1 steps.
  always_comb begin
    d = q;
    if (load) begin
      d.cnt = load_val;
      d.arm = 1'b1;
    end else if (step && q.arm) begin
      if (q.cnt == '0) begin
        d.arm = 1'b0;
      end else begin
        d.cnt = q.cnt - 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign value = q.cnt;
  assign armed = q.arm;

endmodule
`default_nettype wire

// ==== verilog/pfs_sequencer.sv ====
// Program flow sequencer: instruction timing, skips, branches, loops, repeat and power save.
//
// Notes on behaviour
// - Skip: 1, 2 or 3 cycles.
// - Extended compare-branch: 1 untaken, 5 taken.
// - Earlier conditional branch: 1 false, 2 true.
// - Extended taken transfers take 4 cycles.
// - Returns take 3, or 2 with exception pending.
// - Extended returns add three cycles.
// - Hardware loop repeats body count plus one.
// - Repeat runs next instruction count plus one.
// - Timed disable blocks interrupts literal plus one.
// - Long indirect call takes four cycles.
// - Long indirect jump takes four cycles.
// - Double pop: two words, two cycles.
// - Double push: two words, two cycles.
// - Extended peripheral read adds one cycle.
// - Branch evaluates all status flag conditions.
// - Branch tests accumulator overflow and saturation.
// - Interrupt return restores interrupt enable.
// - Return with literal loads ten-bit value.
// - Power save enters literal-selected mode.
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module pfs_sequencer
  import pfs_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Instruction issue.
  input wire logic iss_valid,
  output logic iss_ready,
  input wire logic [4:0] iss_class,
  input wire logic [4:0] iss_cond,
  input wire logic iss_cmp_true,
  input wire logic iss_next_two_word,
  input wire logic iss_periph_read,
  input wire logic iss_use_wreg,
  input wire logic [14:0] iss_lit,
  input wire logic [15:0] iss_wreg,
  input wire logic [3:0] iss_dst,
  input wire logic [PFS_PC_W-1:0] iss_pc,
  input wire logic [PFS_PC_W-1:0] iss_offset,
  // Core status flags.
  input wire logic flag_c,
  input wire logic flag_z,
  input wire logic flag_n,
  input wire logic flag_ov,
  input wire logic flag_oa,
  input wire logic flag_ob,
  input wire logic flag_sa,
  input wire logic flag_sb,
  // Core events.
  input wire logic exc_pending,
  input wire logic wake,
  // Fetch control.
  output logic flush,
  output logic repeat_hold,
  output logic loop_redirect,
  output logic [PFS_PC_W-1:0] loop_target,
  // Interrupt control.
  output logic irq_block,
  output logic irq_enable_restore,
  // Register file and stack.
  output logic reg_wr_en,
  output logic [3:0] reg_wr_idx,
  output logic [15:0] reg_wr_data,
  output logic stack_push,
  output logic stack_pop,
  output logic stack_word,
  // Power save.
  output logic sleep_mode,
  output logic idle_mode
);

  typedef struct packed {
    pfs_state_e st;
    logic [PFS_STALL_W-1:0] stall;
    logic ext;
    logic psmode;
    logic flush;
    logic redirect;
    logic [PFS_PC_W-1:0] loop_start;
    logic [PFS_PC_W-1:0] loop_end;
    logic ie_restore;
    logic wr_en;
    logic [3:0] wr_idx;
    logic [15:0] wr_data;
    logic push;
    logic pop;
    logic word;
    logic [31:0] rdata;
    logic slverr;
  } pfs_seq_s;

  pfs_seq_s q;
  pfs_seq_s d;

  ////////////////////////////////////////////////////////////////////////////////
  // Condition evaluation and issue decode.

  logic cond_true;
  logic take;
  logic [PFS_STALL_W-1:0] cycles;
  logic [PFS_CNT_W-1:0] count_val;
  logic [PFS_CNT_W-1:0] rep_cnt;
  logic [PFS_CNT_W-1:0] loop_cnt;
  logic [PFS_CNT_W-1:0] interrupt_disable_timed_cnt;
  logic rep_armed;
  logic loop_armed;
  logic interrupt_disable_timed_armed;
  logic issue;
  logic loop_hit;
  pfs_class_e cls;

  assign cls = pfs_class_e'(iss_class);
  assign issue = iss_valid && iss_ready;
  assign loop_hit = issue && loop_armed && (iss_pc == q.loop_end);

  // Branch condition from the status flags, signed and unsigned forms included.
  always_comb begin
    unique case (pfs_cond_e'(iss_cond))
      PFS_C_ALWAYS: cond_true = 1'b1;
      PFS_C_C: cond_true = flag_c;
      PFS_C_NC: cond_true = !flag_c;
      PFS_C_Z: cond_true = flag_z;
      PFS_C_NZ: cond_true = !flag_z;
      PFS_C_N: cond_true = flag_n;
      PFS_C_NN: cond_true = !flag_n;
      PFS_C_OV: cond_true = flag_ov;
      PFS_C_NOV: cond_true = !flag_ov;
      PFS_C_GT: cond_true = !flag_z && (flag_n == flag_ov);
      PFS_C_GE: cond_true = (flag_n == flag_ov);
      PFS_C_LT: cond_true = (flag_n != flag_ov);
      PFS_C_LE: cond_true = flag_z || (flag_n != flag_ov);
      PFS_C_GTU: cond_true = flag_c && !flag_z;
      PFS_C_GEU: cond_true = flag_c;
      PFS_C_LTU: cond_true = !flag_c;
      PFS_C_LEU: cond_true = !flag_c || flag_z;
      PFS_C_OA: cond_true = flag_oa;
      PFS_C_OB: cond_true = flag_ob;
      PFS_C_SA: cond_true = flag_sa;
      PFS_C_SB: cond_true = flag_sb;
      default: cond_true = 1'b0;
    endcase
  end

  // Cycle count of the issued instruction and whether it redirects the fetch.
  always_comb begin
    take = 1'b0;
    cycles = PFS_CYC_ONE;
    unique case (cls)
      PFS_SKIP: begin
        if (iss_cmp_true) begin
          cycles = iss_next_two_word ? PFS_CYC_SKIP2 : PFS_CYC_SKIP1;
        end
      end
      PFS_CMP_BRANCH: begin
        take = iss_cmp_true;
        if (take) begin
          cycles = q.ext ? PFS_CYC_CPB_EXT : PFS_CYC_XFER;
        end
      end
      PFS_COND_BRANCH: begin
        take = cond_true;
        if (take) begin
          cycles = q.ext ? PFS_CYC_XFER_EXT : PFS_CYC_XFER;
        end
      end
      PFS_XFER: begin
        take = 1'b1;
        cycles = q.ext ? PFS_CYC_XFER_EXT : PFS_CYC_XFER;
      end
      PFS_LONG_CALL, PFS_LONG_JUMP: begin
        take = 1'b1;
        cycles = PFS_CYC_LONG;
      end
      PFS_RETURN, PFS_INT_RETURN, PFS_RET_LIT: begin
        take = 1'b1;
        cycles = exc_pending ? PFS_CYC_RET_EXC : PFS_CYC_RET;
        if (q.ext) begin
          cycles = cycles + PFS_CYC_RET_EXT_ADD;
        end
      end
      PFS_HW_LOOP, PFS_DPOP, PFS_DPUSH: begin
        cycles = PFS_CYC_TWO;
      end
      PFS_OTHER: begin
        if (q.ext && iss_periph_read) begin
          cycles = PFS_CYC_TWO;
        end
      end
      default: begin
        cycles = PFS_CYC_ONE;
      end
    endcase
  end

  // Count source: a register, or the literal masked to 14 bits on earlier variants.
  always_comb begin
    if (iss_use_wreg) begin
      count_val = iss_wreg;
    end else if (q.ext) begin
      count_val = {1'b0, iss_lit};
    end else begin
      count_val = {2'b00, iss_lit[13:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Counters for single-instruction repeat, hardware loop and timed interrupt block.

  // Each issue while repeat is armed consumes one pass; the repeat itself does not.
  pfs_counter #(.W(PFS_CNT_W)) u_repeat (
    .pclk(pclk),
    .presetn(presetn),
    .load(issue && cls == PFS_REPEAT),
    .load_val(count_val),
    .step(issue && cls != PFS_REPEAT),
    .value(rep_cnt),
    .armed(rep_armed)
  );

  // One step per arrival at the last body instruction.
  pfs_counter #(.W(PFS_CNT_W)) u_loop (
    .pclk(pclk),
    .presetn(presetn),
    .load(issue && cls == PFS_HW_LOOP),
    .load_val(count_val),
    .step(loop_hit),
    .value(loop_cnt),
    .armed(loop_armed)
  );

  // Counts instruction cycles, so stalls count as well.
  pfs_counter #(.W(PFS_CNT_W)) u_interrupt_disable_timed (
    .pclk(pclk),
    .presetn(presetn),
    .load(issue && cls == PFS_INTERRUPT_DISABLE_TIMED),
    .load_val({2'b00, iss_lit[13:0]}),
    .step(1'b1),
    .value(interrupt_disable_timed_cnt),
    .armed(interrupt_disable_timed_armed)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer next state.

  always_comb begin
    d = q;
    d.flush = 1'b0;
    d.redirect = 1'b0;
    d.ie_restore = 1'b0;
    d.wr_en = 1'b0;
    d.push = 1'b0;
    d.pop = 1'b0;
    d.word = 1'b0;
    unique case (q.st)
      PFS_RUN: begin
        if (issue) begin
          if (cycles != PFS_CYC_ONE) begin
            d.st = PFS_STALL;
            d.stall = cycles - PFS_CYC_ONE;
          end
          d.flush = take;
          d.ie_restore = (cls == PFS_INT_RETURN);
          if (cls == PFS_RET_LIT) begin
            d.wr_en = 1'b1;
            d.wr_idx = iss_dst;
            d.wr_data = {6'h00, iss_lit[9:0]};
          end
          d.push = (cls == PFS_DPUSH);
          d.pop = (cls == PFS_DPOP);
          if (cls == PFS_HW_LOOP) begin
            d.loop_start = iss_pc + PFS_LOOP_BODY_STEP;
            d.loop_end = iss_pc + iss_offset;
          end
          if (loop_hit && loop_cnt != '0 && !take) begin
            d.redirect = 1'b1;
          end
          if (cls == PFS_PSAVE) begin
            d.st = PFS_SLEEP;
            d.psmode = iss_lit[0];
          end
        end
      end
      PFS_STALL: begin
        // Second word of a double stack transfer goes out in the cycle after the stall cycle.
        d.push = q.push && !q.word;
        d.pop = q.pop && !q.word;
        d.word = q.push || q.pop;
        d.stall = q.stall - PFS_CYC_ONE;
        if (q.stall == PFS_CYC_ONE) begin
          d.st = PFS_RUN;
        end
      end
      PFS_SLEEP: begin
        // Only a wake event leaves power save; the mode bit stays for software to read.
        if (wake) begin
          d.st = PFS_RUN;
        end
      end
      default: begin
        d.st = PFS_RUN;
      end
    endcase

    // APB register access, answered with no wait state.
    d.rdata = '0;
    d.slverr = 1'b0;
    if (psel && !penable) begin
      unique case (paddr)
        PFS_CTRL_OFF: begin
          d.rdata[PFS_CTRL_EXT_BIT] = q.ext;
        end
        PFS_STATUS_OFF: begin
          d.slverr = pwrite;
          d.rdata[PFS_ST_PSAVE_BIT] = (q.st == PFS_SLEEP);
          d.rdata[PFS_ST_PSMODE_BIT] = q.psmode;
          d.rdata[PFS_ST_REP_BIT] = rep_armed;
          d.rdata[PFS_ST_LOOP_BIT] = loop_armed;
          d.rdata[PFS_ST_BLOCK_BIT] = interrupt_disable_timed_armed;
          d.rdata[PFS_ST_BUSY_BIT] = (q.st != PFS_RUN);
        end
        PFS_REPCNT_OFF: begin
          d.slverr = pwrite;
          d.rdata[PFS_CNT_W-1:0] = rep_cnt;
        end
        PFS_LOOPCNT_OFF: begin
          d.slverr = pwrite;
          d.rdata[PFS_CNT_W-1:0] = loop_cnt;
        end
        default: begin
          d.slverr = 1'b1;
        end
      endcase
    end else if (psel && penable) begin
      d.rdata = q.rdata;
      d.slverr = q.slverr;
      if (pwrite && paddr == PFS_CTRL_OFF) begin
        d.ext = pwdata[PFS_CTRL_EXT_BIT];
      end
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.st <= PFS_RUN;
      q.ext <= PFS_CTRL_EXT_RST;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Ready falls during stalls and power save, which holds the next fetch.
  assign iss_ready = (q.st == PFS_RUN);
  assign pready = 1'b1;
  assign prdata = q.rdata;
  assign pslverr = q.slverr && psel && penable;
  assign flush = q.flush;
  assign repeat_hold = rep_armed;
  assign loop_redirect = q.redirect;
  assign loop_target = q.loop_start;
  assign irq_block = interrupt_disable_timed_armed;
  assign irq_enable_restore = q.ie_restore;
  assign reg_wr_en = q.wr_en;
  assign reg_wr_idx = q.wr_idx;
  assign reg_wr_data = q.wr_data;
  assign stack_push = q.push;
  assign stack_pop = q.pop;
  assign stack_word = q.word;
  assign sleep_mode = (q.st == PFS_SLEEP) && !q.psmode;
  assign idle_mode = (q.st == PFS_SLEEP) && q.psmode;

endmodule
`default_nettype wire

// ==== test/pfs_props.sv ====
// Checker with timing and side-effect properties of the program flow sequencer.
`timescale 1ns/1ns
`default_nettype none
module pfs_props
  import pfs_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Issue side.
  input wire logic iss_valid,
  input wire logic iss_ready,
  input wire logic [4:0] iss_class,
  input wire logic iss_cmp_true,
  input wire logic iss_next_two_word,
  input wire logic [14:0] iss_lit,
  input wire logic [3:0] iss_dst,
  // Results.
  input wire logic flush,
  input wire logic irq_block,
  input wire logic irq_enable_restore,
  input wire logic reg_wr_en,
  input wire logic [3:0] reg_wr_idx,
  input wire logic [15:0] reg_wr_data,
  input wire logic stack_push,
  input wire logic stack_pop,
  input wire logic stack_word,
  input wire logic sleep_mode,
  input wire logic idle_mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  // An instruction is taken on an edge where valid meets ready.
  logic take;
  logic [9:0] lit10;
  assign take = iss_valid && iss_ready;
  assign lit10 = iss_lit[9:0];
  // The two stack words must come in order, first word then second word.
  sequence push_words;
    stack_push && !stack_word ##1 stack_push && stack_word;
  endsequence
  sequence pop_words;
    stack_pop && !stack_word ##1 stack_pop && stack_word;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  AST_PUSH_TWO: assert property (take && iss_class == PFS_DPUSH |=> push_words)
    else $error("double push words out of order");
  AST_POP_TWO: assert property (take && iss_class == PFS_DPOP |=> pop_words)
    else $error("double pop words out of order");
  AST_LONG_FOUR: assert property (take && (iss_class == PFS_LONG_CALL ||
    iss_class == PFS_LONG_JUMP) |=> !iss_ready [*3] ##1 iss_ready)
    else $error("long transfer not four cycles");
  AST_SKIP_TWO_WORD: assert property (take && iss_class == PFS_SKIP && iss_cmp_true &&
    iss_next_two_word |=> !iss_ready [*2] ##1 iss_ready)
    else $error("skip over two words not three cycles");
  AST_SKIP_NONE: assert property (take && iss_class == PFS_SKIP && !iss_cmp_true
    |=> iss_ready && !flush)
    else $error("untaken skip not one cycle");
  AST_RET_LIT: assert property (take && iss_class == PFS_RET_LIT |=> reg_wr_en &&
    reg_wr_idx == $past(iss_dst) && reg_wr_data == {6'h00, $past(lit10)})
    else $error("return literal write wrong");
  AST_IRQ_RESTORE: assert property (take && iss_class == PFS_INT_RETURN
    |=> irq_enable_restore)
    else $error("interrupt return did not restore");
  AST_INTERRUPT_DISABLE_TIMED_START: assert property (take && iss_class == PFS_INTERRUPT_DISABLE_TIMED |=> irq_block)
    else $error("timed disable did not block");
  AST_SLEEP: assert property (take && iss_class == PFS_PSAVE && !iss_lit[0]
    |-> ##[1:2] sleep_mode && !idle_mode)
    else $error("power save zero did not sleep");
  AST_IDLE: assert property (take && iss_class == PFS_PSAVE && iss_lit[0]
    |-> ##[1:2] idle_mode && !sleep_mode)
    else $error("power save one did not idle");
  AST_FLUSH_CAUSE: assert property (flush |-> $past(take))
    else $error("flush without an issue");
endmodule
bind pfs_sequencer pfs_props u_props (.pclk, .presetn, .iss_valid, .iss_ready, .iss_class,
  .iss_cmp_true, .iss_next_two_word, .iss_lit, .iss_dst, .flush, .irq_block,
  .irq_enable_restore, .reg_wr_en, .reg_wr_idx, .reg_wr_data, .stack_push, .stack_pop,
  .stack_word, .sleep_mode, .idle_mode);
`default_nettype wire

// ==== test/pfs_fetch_model.sv ====
// Fetch-side model: presents one instruction on request and times the sequencer's answer.
`timescale 1ns/1ns
`default_nettype none
module pfs_fetch_model (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Request from the bench and answer of the sequencer.
  input wire logic go,
  input wire logic iss_ready,
  input wire logic flush,
  input wire logic loop_redirect,
  // Presented instruction and measured timing.
  output logic iss_valid,
  output logic [3:0] cyc,
  output logic [1:0] seen,
  output logic done
);
  logic busy_q;
  // Valid is held until taken; cycles count until ready returns, fetch events are collected.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iss_valid <= 1'b0;
      cyc <= 4'h0;
      seen <= 2'h0;
      done <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      done <= 1'b0;
      if (go) begin
        iss_valid <= 1'b1;
      end
      if (iss_valid && iss_ready) begin
        iss_valid <= 1'b0;
        busy_q <= 1'b1;
        cyc <= 4'h1;
        seen <= 2'h0;
      end
      if (busy_q) begin
        seen <= seen | {loop_redirect, flush};
        if (iss_ready) begin
          busy_q <= 1'b0;
          done <= 1'b1;
        end else begin
          cyc <= cyc + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking testbench of the program flow sequencer.
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import pfs_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
  logic [7:0] paddr = 8'h00, flags = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, iss_valid, iss_ready, done, flush, repeat_hold, loop_redirect;
  logic [4:0] iss_class = 5'h00, iss_cond = 5'h00;
  logic iss_cmp_true = 1'b0, iss_next_two_word = 1'b0, iss_periph_read = 1'b0;
  logic iss_use_wreg = 1'b0, exc_pending = 1'b0, wake = 1'b0;
  logic [14:0] iss_lit = 15'h0;
  logic [15:0] iss_wreg = 16'h0, reg_wr_data;
  logic [3:0] iss_dst = 4'h0, cyc, reg_wr_idx;
  logic [23:0] iss_pc = 24'h0, iss_offset = 24'h0, loop_target;
  logic irq_block, irq_enable_restore, reg_wr_en, stack_push, stack_pop, stack_word;
  logic sleep_mode, idle_mode;
  logic [1:0] seen;
  int fail_count = 0, tests_run = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // Design, fetch model and a 50 MHz clock.
  pfs_sequencer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .iss_valid, .iss_ready, .iss_class, .iss_cond, .iss_cmp_true,
    .iss_next_two_word, .iss_periph_read, .iss_use_wreg, .iss_lit, .iss_wreg, .iss_dst,
    .iss_pc, .iss_offset, .flag_c(flags[0]), .flag_z(flags[1]), .flag_n(flags[2]),
    .flag_ov(flags[3]), .flag_oa(flags[4]), .flag_ob(flags[5]), .flag_sa(flags[6]),
    .flag_sb(flags[7]), .exc_pending, .wake, .flush, .repeat_hold, .loop_redirect,
    .loop_target, .irq_block, .irq_enable_restore, .reg_wr_en, .reg_wr_idx, .reg_wr_data,
    .stack_push, .stack_pop, .stack_word, .sleep_mode, .idle_mode);
  pfs_fetch_model u_fetch (.pclk, .presetn, .go, .iss_ready, .flush, .loop_redirect,
    .iss_valid, .cyc, .seen, .done);
  always #10 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////////
  // Expected cycles of one instruction class.
  function automatic int exp_cyc(input logic [4:0] c, input logic e, t, w, x, p);
    case (c)
      PFS_SKIP: return !t ? 1 : (w ? 3 : 2);
      PFS_CMP_BRANCH: return !t ? 1 : (e ? 5 : 2);
      PFS_COND_BRANCH, PFS_XFER: return !t ? 1 : (e ? 4 : 2);
      PFS_LONG_CALL, PFS_LONG_JUMP: return 4;
      PFS_RETURN, PFS_INT_RETURN, PFS_RET_LIT: return (x ? 2 : 3) + (e ? 3 : 0);
      PFS_DPOP, PFS_DPUSH: return 2;
      default: return (e && p) ? 2 : 1;
    endcase
  endfunction
  // Expected truth of a branch condition; flags are {sb,sa,ob,oa,ov,n,z,c}.
  function automatic logic cond_ok(input logic [4:0] k, input logic [7:0] f);
    logic s;
    logic [20:0] r;
    s = f[2] ^ f[3];
    r = {f[7:4], !f[0] | f[1], !f[0], f[0], f[0] & !f[1], f[1] | s, s, !s, !f[1] & !s,
      !f[3], f[3], !f[2], f[2], !f[1], f[1], !f[0], f[0], 1'b1};
    return r[k];
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  task automatic report_and_stop();
    if (fail_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // APB transfer; the request stands until pready is seen at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int j;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (j = 0; j < 20; j++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    e = pslverr;
    if (j == 20) chk(32'h0, 32'h1, "apb timeout");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic start(input logic [4:0] c, input logic [14:0] lit);
    iss_class <= c;
    iss_lit <= lit;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
  endtask
  // Waits for the model's completion; a hang ends the run.
  task automatic wait_done();
    int j;
    for (j = 0; j < 40 && done !== 1'b1; j++) @(posedge pclk);
    if (done !== 1'b1) begin
      chk(32'h0, 32'h1, "issue timeout");
      report_and_stop();
    end
  endtask
  task automatic issue(input logic [4:0] c, input logic [14:0] lit);
    start(c, lit);
    wait_done();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: registers, random timing mix, repeat, loop, timed disable, power save.
  initial begin
    logic [31:0] q;
    logic [7:0] f;
    logic [4:0] c;
    logic [4:0] lst [12];
    logic e, t, xe, cm, tw, ex, pr;
    int i, k, n;
    lst = '{PFS_OTHER, PFS_SKIP, PFS_CMP_BRANCH, PFS_COND_BRANCH, PFS_XFER, PFS_LONG_CALL,
      PFS_LONG_JUMP, PFS_RETURN, PFS_INT_RETURN, PFS_RET_LIT, PFS_DPOP, PFS_DPUSH};
    void'($urandom(37195));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, PFS_CTRL_OFF, 32'h0, q, e);
    chk(q, 32'h0, "ctrl reset");
    apb(1'b1, 8'h10, 32'h1, q, e);
    chk({31'h0, e}, 32'h1, "unmapped error");
    apb(1'b1, PFS_STATUS_OFF, 32'h3F, q, e);
    chk({31'h0, e}, 32'h1, "read-only error");
    for (i = 0; i < 240; i++) begin
      if (i % 60 == 0) begin
        xe = 1'((i / 60) % 2);
        apb(1'b1, PFS_CTRL_OFF, {31'h0, xe}, q, e);
        apb(1'b0, PFS_CTRL_OFF, 32'h0, q, e);
        chk(q, {31'h0, xe}, "ctrl readback");
      end
      c = lst[$urandom_range(11)];
      k = $urandom_range(20);
      f = 8'($urandom);
      cm = 1'($urandom);
      tw = 1'($urandom);
      ex = 1'($urandom);
      pr = (c == PFS_OTHER) && 1'($urandom);
      iss_cond <= 5'(k);
      flags <= f;
      iss_cmp_true <= cm;
      iss_next_two_word <= tw;
      exc_pending <= ex;
      iss_periph_read <= pr;
      iss_dst <= 4'($urandom);
      t = (c == PFS_SKIP || c == PFS_CMP_BRANCH) ? cm :
        (c == PFS_COND_BRANCH) ? cond_ok(5'(k), f) : 1'b1;
      issue(c, 15'($urandom));
      chk(32'(cyc), exp_cyc(c, xe, t, tw, ex, pr),
        "cycles");
      if (c != PFS_SKIP) chk({31'h0, seen[0]}, {31'h0, t && c != PFS_OTHER &&
        c != PFS_DPOP && c != PFS_DPUSH}, "flush");
    end
    apb(1'b1, PFS_CTRL_OFF, 32'h0, q, e);
    // Repeat by literal 17 ahead of plain instructions, then by working register 2.
    for (k = 0; k < 2; k++) begin
      iss_use_wreg <= k[0];
      iss_wreg <= 16'h0002;
      issue(PFS_REPEAT, 15'h011);
      chk(32'(cyc), 32'h1, "repeat cycles");
      n = 0;
      for (i = 0; i < 30 && (n == 0 || repeat_hold === 1'b1); i++) begin
        issue(PFS_OTHER, 15'h0);
        n++;
      end
      chk(32'(n), k ? 32'h3 : 32'h12, "repeat passes");
    end
    iss_use_wreg <= 1'b0;
    iss_pc <= 24'h000100;
    iss_offset <= 24'h000008;
    issue(PFS_HW_LOOP, 15'h002);
    chk(32'(cyc), 32'h2, "loop cycles");
    apb(1'b0, PFS_LOOPCNT_OFF, 32'h0, q, e);
    chk(q, 32'h2, "loop count");
    iss_pc <= 24'h000108;
    n = 0;
    for (i = 0; i < 4; i++) begin
      issue(PFS_OTHER, 15'h0);
      n += seen[1];
    end
    chk(32'(n), 32'h2, "loop redirects");
    chk({8'h00, loop_target}, 32'h104, "loop target");
    issue(PFS_INTERRUPT_DISABLE_TIMED, 15'h005);
    n = 1;
    for (i = 0; i < 40 && irq_block === 1'b1; i++) begin
      n++;
      @(posedge pclk);
    end
    chk(32'(n), 32'h6, "disable length");
    // Power save in both modes, left by wake.
    for (k = 0; k < 2; k++) begin
      start(PFS_PSAVE, 15'(k));
      repeat (4) @(posedge pclk);
      chk({30'h0, idle_mode, sleep_mode}, k ? 32'h2 : 32'h1, "power save mode");
      wake <= 1'b1;
      wait_done();
      wake <= 1'b0;
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
